// File: src/bsr_top.v
/*
 * bsr_top: boundary-scan data register with its instruction decode, test
 * port sequencing and pin/core muxing.
 * assumes: tck, tms, tdi and every pin input are asynchronous to clock and
 * are synchronised here; core_* inputs come from logic on clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "bsr_defines.vh"

module bsr_top #(
    parameter FULL_PIN = 1
) (
    input  wire        clock,
    input  wire        rst,
    input  wire        tck,
    input  wire        tms,
    input  wire        tdi,
    output reg         tdo,
    output reg         tdo_oe,
    input  wire        core_rst_drive_en,
    input  wire        core_canrx_oe,
    input  wire        core_canrx_out,
    input  wire        core_cantx_oe,
    input  wire        core_cantx_out,
    input  wire        core_weak_pullup_en,
    input  wire [63:0] core_port_oe,
    input  wire [63:0] core_port_out,
    input  wire        pin_rst_in,
    input  wire        pin_canrx_in,
    input  wire        pin_cantx_in,
    input  wire        crystal_input_pin,
    input  wire [63:0] port_pin_in,
    output reg         pin_rst_oe,
    output reg         pin_canrx_oe,
    output reg         pin_canrx_out,
    output reg         pin_cantx_oe,
    output reg         pin_cantx_out,
    output reg         weak_pullup_en,
    output reg  [63:0] port_pin_oe,
    output reg  [63:0] port_pin_out,
    output reg         core_rst_in,
    output reg         core_canrx_in,
    output reg         core_cantx_in,
    output reg         core_xtal_in,
    output reg  [63:0] core_port_in
);

    localparam LEN      = FULL_PIN ? `BSR_LEN_FULL : `BSR_LEN_REDUCED;
    localparam RST_OE_C = FULL_PIN ? `BSR_CELL_RST_OE_FULL : `BSR_CELL_RST_OE_RED;
    localparam RST_IN_C = FULL_PIN ? `BSR_CELL_RST_IN_FULL : `BSR_CELL_RST_IN_RED;

    localparam [15:0] S_TLR  = 16'h0001;
    localparam [15:0] S_CDR  = 16'h0008;
    localparam [15:0] S_SHDR = 16'h0010;
    localparam [15:0] S_UDR  = 16'h0100;
    localparam [15:0] S_CIR  = 16'h0400;
    localparam [15:0] S_SHIR = 16'h0800;
    localparam [15:0] S_UIR  = 16'h8000;

    // output enable cell of a port pin, -1 when the pin has no cell
    function integer oe_cell;
        input integer i;
        input integer full;
        integer p;
        integer n;
        begin
            p = i / 8;
            n = i % 8;
            oe_cell = -1;
            if (p < 4) begin
                oe_cell = `BSR_PORT0_BASE + `BSR_PORT_STRIDE * p + 2 * n;
            end else if (p == 4) begin
                if (full != 0 && n >= `BSR_PORT4_FIRST_PIN)
                    oe_cell = `BSR_PORT4_BASE + 2 * (n - `BSR_PORT4_FIRST_PIN);
            end else if (p == 5) begin
                if (full != 0)
                    oe_cell = `BSR_PORT5_FULL + 2 * n;
                else if (n < 4)
                    oe_cell = `BSR_PORT5_RED + 2 * n;
                else if (n == 5)
                    oe_cell = `BSR_PORT5_RED + 8;
                else if (n == 7)
                    oe_cell = `BSR_PORT5_RED + 10;
            end else if (p == 6) begin
                oe_cell = (full != 0) ? `BSR_PORT6_FULL + 2 * n : `BSR_PORT6_RED + 2 * n;
            end else begin
                oe_cell = (full != 0) ? `BSR_PORT7_FULL + 2 * n : `BSR_PORT7_RED + 2 * n;
            end
        end
    endfunction

    // synchronised pins
    wire [70:0] sync_q;
    wire        tck_s    = sync_q[0];
    wire        tms_s    = sync_q[1];
    wire        tdi_s    = sync_q[2];
    wire        rst_s    = sync_q[3];
    wire        canrx_s  = sync_q[4];
    wire        cantx_s  = sync_q[5];
    wire        xtal_s   = sync_q[6];
    wire [63:0] port_s   = sync_q[70:7];

    bsr_sync #(
        .W (71)
    ) u_sync (
        .clock    (clock),
        .rst      (rst),
        .async_in ({port_pin_in, crystal_input_pin, pin_cantx_in, pin_canrx_in, pin_rst_in, tdi, tms, tck}),
        .sync_out (sync_q)
    );

    // test clock edges
    reg  tck_d;
    wire tck_rise = tck_s & ~tck_d;
    wire tck_fall = ~tck_s & tck_d;

    always @(posedge clock) begin
        if (rst)
            tck_d <= 1'b0;
        else
            tck_d <= tck_s;
    end

    wire [15:0] state;

    bsr_tap u_tap (
        .clock    (clock),
        .rst      (rst),
        .tck_rise (tck_rise),
        .tms      (tms_s),
        .state    (state)
    );

    // instruction register
    reg  [`BSR_IR_W-1:0] ir_sr;
    reg  [`BSR_IR_W-1:0] ir;
    wire extest   = (ir == `BSR_IR_EXTEST);
    wire instr_a  = (ir == `BSR_IR_INSTR_A);
    wire selected = extest | instr_a;

    always @(posedge clock) begin
        if (rst) begin
            ir_sr <= `BSR_IR_RESET;
            ir    <= `BSR_IR_RESET;
        end else if (tck_rise) begin
            case (state)
                S_TLR:   ir <= `BSR_IR_RESET;
                S_CIR:   ir_sr <= `BSR_IR_CAPTURE;
                S_SHIR:  ir_sr <= {tdi_s, ir_sr[`BSR_IR_W-1:1]};
                S_UIR:   ir <= ir_sr;
                default: ir <= ir;
            endcase
        end
    end

    // capture vector
    wire [LEN-1:0]  cap;
    reg  [LEN-1:0]  sr;
    reg  [LEN-1:0]  upd;
    wire [63:0]     ext_oe;
    wire [63:0]     ext_out;
    wire [63:0]     has_pin;

    assign cap[RST_OE_C]            = core_rst_drive_en;
    assign cap[RST_IN_C]            = rst_s;
    assign cap[`BSR_CELL_CANRX_OE]  = core_canrx_oe;
    assign cap[`BSR_CELL_CANRX_DAT] = canrx_s;
    assign cap[`BSR_CELL_CANTX_OE]  = core_cantx_oe;
    assign cap[`BSR_CELL_CANTX_DAT] = cantx_s;
    assign cap[`BSR_CELL_XTAL]      = xtal_s;
    assign cap[`BSR_CELL_WPU]       = core_weak_pullup_en;

    generate
        if (FULL_PIN == 0) begin : g_unused
            assign cap[1:0] = 2'h0;
        end
    endgenerate

    genvar gi;
    generate
        for (gi = 0; gi < 64; gi = gi + 1) begin : g_pin
            localparam integer OE_C = oe_cell(gi, FULL_PIN);
            localparam CONN = (OE_C >= 0) && (FULL_PIN != 0 || gi < 48);
            if (OE_C >= 0) begin : g_cell
                assign cap[OE_C]     = core_port_oe[gi];
                assign cap[OE_C + 1] = CONN ? port_s[gi] : core_port_out[gi];
                assign ext_oe[gi]    = upd[OE_C];
                assign ext_out[gi]   = upd[OE_C + 1];
            end else begin : g_none
                assign ext_oe[gi]    = 1'b0;
                assign ext_out[gi]   = 1'b0;
            end
            assign has_pin[gi] = CONN ? 1'b1 : 1'b0;
        end
    endgenerate

    // shift and update stages
    always @(posedge clock) begin
        if (rst) begin
            sr  <= {LEN{1'b0}};
            upd <= {LEN{1'b0}};
        end else if (tck_rise && selected) begin
            case (state)
                S_CDR:   sr <= cap;
                S_SHDR:  sr <= {tdi_s, sr[LEN-1:1]};
                S_UDR:   upd <= sr;
                default: sr <= sr;
            endcase
        end
    end

    // test data output, changes on falling test clock
    always @(posedge clock) begin
        if (rst) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe <= (state == S_SHDR) || (state == S_SHIR);
            if (state == S_SHIR)
                tdo <= ir_sr[0];
            else if (state == S_SHDR && selected)
                tdo <= sr[0];
            else
                tdo <= 1'b0;
        end
    end

    // pin and core muxing
    always @(posedge clock) begin
        if (rst) begin
            pin_rst_oe     <= 1'b0;
            pin_canrx_oe   <= 1'b0;
            pin_canrx_out  <= 1'b0;
            pin_cantx_oe   <= 1'b0;
            pin_cantx_out  <= 1'b0;
            weak_pullup_en <= 1'b0;
            port_pin_oe    <= 64'h0;
            port_pin_out   <= 64'h0;
            core_rst_in    <= 1'b1;
            core_canrx_in  <= 1'b1;
            core_cantx_in  <= 1'b1;
            core_xtal_in   <= 1'b0;
            core_port_in   <= 64'h0;
        end else if (extest) begin
            pin_rst_oe     <= upd[RST_OE_C];
            pin_canrx_oe   <= upd[`BSR_CELL_CANRX_OE];
            pin_canrx_out  <= upd[`BSR_CELL_CANRX_DAT];
            pin_cantx_oe   <= upd[`BSR_CELL_CANTX_OE];
            pin_cantx_out  <= upd[`BSR_CELL_CANTX_DAT];
            weak_pullup_en <= upd[`BSR_CELL_WPU];
            port_pin_oe    <= (ext_oe & has_pin) | (core_port_oe & ~has_pin);
            port_pin_out   <= (ext_out & has_pin) | (core_port_out & ~has_pin);
            core_rst_in    <= 1'b1;
            core_canrx_in  <= 1'b1;
            core_cantx_in  <= 1'b1;
            core_xtal_in   <= 1'b1;
            core_port_in   <= {64{1'b1}};
        end else begin
            pin_rst_oe     <= core_rst_drive_en;
            pin_canrx_oe   <= core_canrx_oe;
            pin_canrx_out  <= core_canrx_out;
            pin_cantx_oe   <= core_cantx_oe;
            pin_cantx_out  <= core_cantx_out;
            weak_pullup_en <= core_weak_pullup_en;
            port_pin_oe    <= core_port_oe;
            port_pin_out   <= core_port_out;
            core_rst_in    <= rst_s;
            core_canrx_in  <= canrx_s;
            core_cantx_in  <= cantx_s;
            core_xtal_in   <= xtal_s;
            core_port_in   <= port_s;
        end
    end

endmodule

`default_nettype wire

// File: src/bsr_defines.vh
/*
 * bsr_defines.vh: chain lengths, cell positions and instruction codes of the
 * boundary-scan data register.
 * assumes: included by bare name from the design files under src/.
 */
`ifndef BSR_DEFINES_VH
`define BSR_DEFINES_VH

// chain lengths
`define BSR_LEN_FULL        126
`define BSR_LEN_REDUCED     118

// fixed cells
`define BSR_CELL_RST_OE_FULL 0
`define BSR_CELL_RST_IN_FULL 1
`define BSR_CELL_RST_OE_RED  72
`define BSR_CELL_RST_IN_RED  73
`define BSR_CELL_CANRX_OE    2
`define BSR_CELL_CANRX_DAT   3
`define BSR_CELL_CANTX_OE    4
`define BSR_CELL_CANTX_DAT   5
`define BSR_CELL_XTAL        6
`define BSR_CELL_WPU         7

// port cell bases (output enable cell of pin 0, of pin 5 on port 4)
`define BSR_PORT0_BASE      8
`define BSR_PORT_STRIDE     16
`define BSR_PORT4_BASE      72
`define BSR_PORT4_FIRST_PIN 5
`define BSR_PORT5_FULL      78
`define BSR_PORT6_FULL      94
`define BSR_PORT7_FULL      110
`define BSR_PORT5_RED       74
`define BSR_PORT6_RED       86
`define BSR_PORT7_RED       102

// instruction register
`define BSR_IR_W            16
`define BSR_IR_EXTEST       16'h0000
`define BSR_IR_INSTR_A      16'h0002
`define BSR_IR_RESET        16'h0004
`define BSR_IR_CAPTURE      16'h0001

`endif

// File: src/bsr_sync.v
/*
 * bsr_sync: two-flop synchroniser for a group of asynchronous levels.
 * assumes: inputs are quasi-static levels or a slow test clock.
 */
`timescale 1ns/100ps
`default_nettype none

module bsr_sync #(
    parameter W = 1
) (
    input  wire         clock,
    input  wire         rst,
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);

    reg [W-1:0] meta;

    always @(posedge clock) begin
        if (rst) begin
            meta     <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule

`default_nettype wire

// File: src/bsr_tap.v
/*
 * bsr_tap: test-port state controller, one step per test clock rising edge.
 * assumes: tck_rise is a one-cycle enable, tms already synchronised.
 */
`timescale 1ns/100ps
`default_nettype none

module bsr_tap (
    input  wire        clock,
    input  wire        rst,
    input  wire        tck_rise,
    input  wire        tms,
    output reg  [15:0] state
);

    localparam [15:0] S_TLR  = 16'h0001;
    localparam [15:0] S_RTI  = 16'h0002;
    localparam [15:0] S_SDR  = 16'h0004;
    localparam [15:0] S_CDR  = 16'h0008;
    localparam [15:0] S_SHDR = 16'h0010;
    localparam [15:0] S_E1DR = 16'h0020;
    localparam [15:0] S_PDR  = 16'h0040;
    localparam [15:0] S_E2DR = 16'h0080;
    localparam [15:0] S_UDR  = 16'h0100;
    localparam [15:0] S_SIR  = 16'h0200;
    localparam [15:0] S_CIR  = 16'h0400;
    localparam [15:0] S_SHIR = 16'h0800;
    localparam [15:0] S_E1IR = 16'h1000;
    localparam [15:0] S_PIR  = 16'h2000;
    localparam [15:0] S_E2IR = 16'h4000;
    localparam [15:0] S_UIR  = 16'h8000;

    reg [15:0] next_state;

    always @* begin
        case (state)
            S_TLR:   next_state = tms ? S_TLR  : S_RTI;
            S_RTI:   next_state = tms ? S_SDR  : S_RTI;
            S_SDR:   next_state = tms ? S_SIR  : S_CDR;
            S_CDR:   next_state = tms ? S_E1DR : S_SHDR;
            S_SHDR:  next_state = tms ? S_E1DR : S_SHDR;
            S_E1DR:  next_state = tms ? S_UDR  : S_PDR;
            S_PDR:   next_state = tms ? S_E2DR : S_PDR;
            S_E2DR:  next_state = tms ? S_UDR  : S_SHDR;
            S_UDR:   next_state = tms ? S_SDR  : S_RTI;
            S_SIR:   next_state = tms ? S_TLR  : S_CIR;
            S_CIR:   next_state = tms ? S_E1IR : S_SHIR;
            S_SHIR:  next_state = tms ? S_E1IR : S_SHIR;
            S_E1IR:  next_state = tms ? S_UIR  : S_PIR;
            S_PIR:   next_state = tms ? S_E2IR : S_PIR;
            S_E2IR:  next_state = tms ? S_UIR  : S_SHIR;
            S_UIR:   next_state = tms ? S_SDR  : S_RTI;
            default: next_state = S_TLR;
        endcase
    end

    always @(posedge clock) begin
        if (rst) begin
            state <= S_TLR;
        end else if (tck_rise) begin
            state <= next_state;
        end
    end

endmodule

`default_nettype wire

// File: verification/bsr_top_properties.sv
/*
 * bsr_top_properties: port-level checks of the boundary register.
 * assumes: bound into every bsr_top, full or reduced, test clock far slower than clock.
 */
`timescale 1ns/100ps
`default_nettype none
module bsr_top_properties (
    input wire        clock,
    input wire        rst,
    input wire        tck,
    input wire        tdo,
    input wire        tdo_oe,
    input wire        pin_canrx_in,
    input wire        core_canrx_in,
    input wire        core_cantx_oe,
    input wire        pin_cantx_oe,
    input wire        core_weak_pullup_en,
    input wire        weak_pullup_en,
    input wire        core_rst_drive_en,
    input wire        pin_rst_oe,
    input wire [63:0] core_port_out,
    input wire [63:0] port_pin_out,
    input wire        core_rst_in,
    input wire        core_xtal_in,
    input wire [63:0] core_port_in
);
    reg  [2:0] settle;
    reg  [3:0] rx_hist;
    wire       ext = core_rst_in & core_xtal_in & (&core_port_in);
    always @(posedge clock) begin
        if (rst)
            settle <= 3'h0;
        else if (settle != 3'h7)
            settle <= settle + 3'h1;
        rx_hist <= {rx_hist[2:0], pin_canrx_in};
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // a pin drive that leaves a steady core value is only allowed in external test
    property follows_or_ext(logic p, logic c);
        settle == 3'h7 && $stable(c) && p != c |-> ext;
    endproperty
    rst_oe_follow_a: assert property (follows_or_ext(pin_rst_oe, core_rst_drive_en))
        else $error("reset enable off core outside external test");
    cantx_oe_follow_a: assert property (follows_or_ext(pin_cantx_oe, core_cantx_oe))
        else $error("tx enable off core outside external test");
    pullup_follow_a: assert property (follows_or_ext(weak_pullup_en, core_weak_pullup_en))
        else $error("pullup enable off core outside external test");
    port_out_follow_a: assert property (settle == 3'h7 && $stable(core_port_out) &&
        port_pin_out[31:0] != core_port_out[31:0] |-> ext) else $error("port data off core outside external test");
    core_forced_a: assert property (settle == 3'h7 && (&{rx_hist, pin_canrx_in} || ~|{rx_hist, pin_canrx_in}) &&
        core_canrx_in != pin_canrx_in |-> ext) else $error("core input off pin outside external test");
    update_on_rise_a: assert property (ext && $past(ext) && $changed(port_pin_out[31:0]) |-> $past(tck, 2))
        else $error("pin drive changed away from test clock rise");
    tdo_on_fall_a: assert property ($changed(tdo) |-> !tck && !$past(tck, 2))
        else $error("test data out changed away from test clock fall");
    tdo_oe_fall_a: assert property ($changed(tdo_oe) |-> !tck && !$past(tck, 2))
        else $error("test data enable changed away from test clock fall");
    cover property (ext && $changed(port_pin_out));
    cover property ($rose(tdo_oe));
    cover property ($fell(ext));
endmodule
bind bsr_top bsr_top_properties u_props (.clock, .rst, .tck, .tdo, .tdo_oe, .pin_canrx_in, .core_canrx_in,
    .core_cantx_oe, .pin_cantx_oe, .core_weak_pullup_en, .weak_pullup_en, .core_rst_drive_en, .pin_rst_oe,
    .core_port_out, .port_pin_out, .core_rst_in, .core_xtal_in, .core_port_in);
`default_nettype wire

// File: verification/bsr_tester.sv
/*
 * bsr_tester: scan tester model driving the test port at 125 ns per bit.
 * assumes: test clock stands low between steps; tdo sampled before each rise.
 */
`timescale 1ns/100ps
`default_nettype none
module bsr_tester (
    output logic tck,
    output logic tms,
    output logic tdi,
    input  wire  tdo,
    input  wire  tdo_alt
);
    logic         qa;
    logic [255:0] alt_out;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #31.2 q = tdo;
        qa = tdo_alt;
        tck = 1'b1;
        #62.5 tck = 1'b0;
        #31.3;
    endtask
    task automatic reset_tap();
        logic q;
        repeat (5) step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
    endtask
    // from idle through one shift of n bits to update and back to idle
    task automatic scan(input logic ir, input int n, input logic [255:0] din, output logic [255:0] dout);
        logic q;
        dout = '0;
        alt_out = '0;
        step(1'b1, ~tdi, q);
        if (ir)
            step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
        step(1'b0, ~tdi, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
            alt_out[i] = qa;
        end
        step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
    endtask
endmodule
`default_nettype wire

// File: verification/boundary_scan_register_tb.sv
/*
 * boundary_scan_register_tb: random and corner scans through the register.
 * assumes: full-pin dut and reduced-pin dut share one tester and all inputs.
 */
`timescale 1ns/100ps
`default_nettype none
module boundary_scan_register_tb;
    logic        clock, rst, tck, tms, tdi, tdo, tdo_oe, tdo_red;
    logic        core_rst_drive_en, core_canrx_oe, core_canrx_out, core_cantx_oe, core_cantx_out;
    logic        core_weak_pullup_en, pin_rst_in, pin_canrx_in, pin_cantx_in, crystal_input_pin;
    logic [63:0] core_port_oe, core_port_out, port_pin_in, port_pin_oe, port_pin_out, core_port_in;
    logic        pin_rst_oe, pin_canrx_oe, pin_canrx_out, pin_cantx_oe, pin_cantx_out, weak_pullup_en;
    logic        core_rst_in, core_canrx_in, core_cantx_in, core_xtal_in;
    logic [255:0] din, d, exp, er;
    logic [31:0] r, seed;
    int          error_cnt, comparisons, cycles;

    bsr_top #(.FULL_PIN(1)) dut (.clock(clock), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe), .core_rst_drive_en(core_rst_drive_en), .core_canrx_oe(core_canrx_oe),
        .core_canrx_out(core_canrx_out), .core_cantx_oe(core_cantx_oe), .core_cantx_out(core_cantx_out),
        .core_weak_pullup_en(core_weak_pullup_en), .core_port_oe(core_port_oe), .core_port_out(core_port_out),
        .pin_rst_in(pin_rst_in), .pin_canrx_in(pin_canrx_in), .pin_cantx_in(pin_cantx_in),
        .crystal_input_pin(crystal_input_pin), .port_pin_in(port_pin_in), .pin_rst_oe(pin_rst_oe),
        .pin_canrx_oe(pin_canrx_oe), .pin_canrx_out(pin_canrx_out), .pin_cantx_oe(pin_cantx_oe),
        .pin_cantx_out(pin_cantx_out), .weak_pullup_en(weak_pullup_en), .port_pin_oe(port_pin_oe),
        .port_pin_out(port_pin_out), .core_rst_in(core_rst_in), .core_canrx_in(core_canrx_in),
        .core_cantx_in(core_cantx_in), .core_xtal_in(core_xtal_in), .core_port_in(core_port_in));
    bsr_top #(.FULL_PIN(0)) dut_red (.clock(clock), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_red),
        .tdo_oe(), .core_rst_drive_en(core_rst_drive_en), .core_canrx_oe(core_canrx_oe),
        .core_canrx_out(core_canrx_out), .core_cantx_oe(core_cantx_oe), .core_cantx_out(core_cantx_out),
        .core_weak_pullup_en(core_weak_pullup_en), .core_port_oe(core_port_oe), .core_port_out(core_port_out),
        .pin_rst_in(pin_rst_in), .pin_canrx_in(pin_canrx_in), .pin_cantx_in(pin_cantx_in),
        .crystal_input_pin(crystal_input_pin), .port_pin_in(port_pin_in), .pin_rst_oe(), .pin_canrx_oe(),
        .pin_canrx_out(), .pin_cantx_oe(), .pin_cantx_out(), .weak_pullup_en(), .port_pin_oe(), .port_pin_out(),
        .core_rst_in(), .core_canrx_in(), .core_cantx_in(), .core_xtal_in(), .core_port_in());
    bsr_tester tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_alt(tdo_red));

    always #4 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic conclude();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [255:0] seen, input logic [255:0] e);
        comparisons++;
        if (seen !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, e, seen);
        end
    endtask
    function automatic int cell_of(input int b);
        int p;
        int n;
        p = b / 8;
        n = b % 8;
        if (p < 4) return 8 + 16 * p + 2 * n;
        if (p == 4) return (n < 5) ? -1 : 72 + 2 * (n - 5);
        return 78 + 16 * (p - 5) + 2 * n;
    endfunction
    // reduced chain: port 4 gone, port 5 pins 0,1,2,3,5,7, ports 6/7 from 86
    function automatic int cell_red(input int b);
        int n;
        n = b % 8;
        if (b < 32) return cell_of(b);
        if (b < 40) return -1;
        if (b < 48) return (n == 4 || n == 6) ? -1 : 74 + 2 * (n - (n > 4) - (n > 6));
        return 86 + 16 * (b / 8 - 6) + 2 * n;
    endfunction
    function automatic logic [255:0] cap_of(input logic full);
        logic [255:0] v;
        int c;
        v = '0;
        v[1:0] = {pin_rst_in, core_rst_drive_en};
        v[5:2] = {pin_cantx_in, core_cantx_oe, pin_canrx_in, core_canrx_oe};
        v[7:6] = {core_weak_pullup_en, crystal_input_pin};
        for (int b = 0; b < 64; b++) begin
            c = full ? cell_of(b) : cell_red(b);
            if (c >= 0)
                v[c+:2] = {(full || b < 48) ? port_pin_in[b] : core_port_out[b], core_port_oe[b]};
        end
        if (!full) begin
            v[73:72] = v[1:0];
            v[1:0] = 2'h0;
        end
        return v;
    endfunction
    task automatic rand_in();
        @(negedge clock);
        r = $random(seed);
        {core_rst_drive_en, core_canrx_oe, core_canrx_out, core_cantx_oe, core_cantx_out} = r[4:0];
        {core_weak_pullup_en, pin_rst_in, pin_canrx_in, pin_cantx_in, crystal_input_pin} = r[9:5];
        core_port_oe = {$random(seed), $random(seed)};
        core_port_out = {$random(seed), $random(seed)};
        port_pin_in = {$random(seed), $random(seed)};
        for (int j = 0; j < 8; j++)
            din[32*j+:32] = $random(seed);
    endtask
    task automatic check_pins(input logic ext, input logic [255:0] u);
        logic [63:0] eoe;
        logic [63:0] eout;
        repeat (8) @(negedge clock);
        eoe = core_port_oe;
        eout = core_port_out;
        for (int b = 0; b < 64; b++)
            if (ext && cell_of(b) >= 0)
                {eout[b], eoe[b]} = u[cell_of(b)+:2];
        check("pin drives", {pin_rst_oe, pin_canrx_oe, pin_canrx_out, pin_cantx_oe, pin_cantx_out, weak_pullup_en},
            ext ? {u[0], u[2], u[3], u[4], u[5], u[7]} : {core_rst_drive_en, core_canrx_oe, core_canrx_out, core_cantx_oe,
            core_cantx_out, core_weak_pullup_en});
        check("port oe", port_pin_oe, eoe);
        check("port out", port_pin_out, eout);
        check("core in", {core_rst_in, core_canrx_in, core_cantx_in, core_xtal_in, core_port_in},
            ext ? {68{1'b1}} : {pin_rst_in, pin_canrx_in, pin_cantx_in, crystal_input_pin, port_pin_in});
    endtask

    initial begin
        seed = 32'h60f6ea38;
        {clock, cycles, error_cnt, comparisons} = '0;
        {core_rst_drive_en, core_canrx_oe, core_canrx_out, core_cantx_oe, core_cantx_out} = '0;
        {core_weak_pullup_en, pin_rst_in, pin_canrx_in, pin_cantx_in, crystal_input_pin} = '0;
        {core_port_oe, core_port_out, port_pin_in} = '0;
        rst = 1'b1;
        repeat (10) @(negedge clock);
        check("reset drives", {pin_rst_oe, pin_canrx_oe, pin_canrx_out, pin_cantx_oe, pin_cantx_out,
            weak_pullup_en, port_pin_oe, port_pin_out, tdo, tdo_oe}, '0);
        rst = 1'b0;
        repeat (4) @(negedge clock);
        tester.reset_tap();
        tester.scan(1'b1, 16, 256'h2, d);
        rand_in();
        exp = cap_of(1'b1);
        er = cap_of(1'b0);
        tester.scan(1'b0, 252, din, d);
        check("sample capture", d[125:0], exp[125:0]);
        check("chain length", d[251:126], din[125:0]);
        check("reduced capture", tester.alt_out[117:0], er[117:0]);
        check("reduced length", tester.alt_out[235:118], din[117:0]);
        check_pins(1'b0, '0);
        exp = din >> 126;
        tester.scan(1'b1, 16, 256'h0, d);
        check_pins(1'b1, exp);
        for (int k = 0; k < 3; k++) begin
            rand_in();
            if (k < 2)
                din = k == 0 ? '1 : '0;
            exp = cap_of(1'b1);
            tester.scan(1'b0, 126, din, d);
            check("extest capture", d[125:0], exp[125:0]);
            exp = din;
            rand_in();
            check_pins(1'b1, exp);
        end
        tester.scan(1'b1, 16, 256'hffff, d);
        tester.scan(1'b0, 126, din, d);
        check("refused scan", d[125:0], '0);
        check_pins(1'b0, '0);
        conclude();
    end
endmodule
`default_nettype wire
